// *** hdl/dsc_chan_ctrl.sv ***
// Control logic of a short address DMA channel pair with an APB register slave.
`include "dsc_regs.svh"

// Overview of operation
// - Each channel's 8-bit control register clears on reset and on standby.
// - An enabled channel runs one transfer each time its source fires.
// - A disabled channel ignores every request from its source.
// - Enable sets only after software read the register with enable low.
// - In I/O and idle mode enable clears itself after the last transfer.
// - Enable falling with interrupt enable high raises the end interrupt.
// - Size bit low means byte transfers, high means word transfers.
// - Direction low increments the memory pointer by 1 or 2.
// - Direction high decrements the memory pointer by 1 or 2.
// - Idle mode never steps the memory pointer.
// - Mode comes from repeat bit and interrupt enable: I/O, repeat, idle.
// - Channel A codes: timers 0-3, serial tx empty, rx full, full mode.
// - Channel B adds falling edge and low level of the request pin.
// - Channels sharing a source are served in fixed order, A first.
// - An enabled channel on codes 0-5 blocks its source's normal CPU interrupt; codes 6 and 7 block none.
// - Memory pointer is destination for rx full, source otherwise.
// - I/O address is the pointer byte under all-ones, never stepped.
// - I/O and idle modes count down 16 bits and stop at zero.
// - Repeat mode counts the high byte and reloads it from the low byte.
module dsc_chan_ctrl
    import dsc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        standby,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  timer_cmp,
    input  wire logic        ser_tx_empty,
    input  wire logic        ser_rx_full,
    input  wire logic        ext_xfer_request_n,
    output logic             xfer_req,
    output logic             xfer_chan,
    output logic             xfer_word,
    output logic [23:0]      xfer_src_addr,
    output logic [23:0]      xfer_dst_addr,
    input  wire logic        xfer_ack,
    output logic [1:0]       transfer_end_irq,
    output logic [5:0]       src_irq_block
);

    // ------------------------------------------------------------------------
    // State and helpers
    // ------------------------------------------------------------------------
    dsc_state_type st;
    dsc_state_type next_st;

    logic        setup;
    logic        acc;
    logic        addr_ok;
    logic        ext_fall;
    logic [1:0]  fire;
    logic [1:0]  rx_src;
    logic [1:0]  full;
    logic [23:0] step_ptr [2];

    assign setup    = psel && !penable && !st.pready;
    assign acc      = psel && penable && st.pready;
    assign addr_ok  = (paddr[1:0] == 2'b00)
                      && ((paddr[7:5] == 3'b000) || (paddr == `DSC_STAT_ADDR));
    assign ext_fall = st.ext_prev && !ext_xfer_request_n;

    function automatic dsc_mode_type mode_of(input logic [7:0] c);
        if (!c[`DSC_BIT_REPEAT]) begin
            mode_of = DSC_MODE_IO;
        end else if (!c[`DSC_BIT_IRQ_EN]) begin
            mode_of = DSC_MODE_REPEAT;
        end else begin
            mode_of = DSC_MODE_IDLE;
        end
    endfunction : mode_of

    function automatic logic [31:0] rd_mux(input dsc_state_type s, input logic [7:0] a);
        dsc_chan_type c;
        c = s.ch[a[4]];
        rd_mux = 32'h0;
        if (a == `DSC_STAT_ADDR) begin
            rd_mux = {30'h0, s.ch[1].end_irq, s.ch[0].end_irq};
        end else if (a[7:5] == 3'b000) begin
            unique case (a[3:0])
                `DSC_OFS_CTRL:    rd_mux = {24'h0, c.ctrl};
                `DSC_OFS_MEM_PTR: rd_mux = {`DSC_MEM_RSVD, c.mem_ptr};
                `DSC_OFS_IO_PTR:  rd_mux = {24'h0, c.io_ptr};
                `DSC_OFS_COUNT:   rd_mux = {16'h0, c.count};
                default:          rd_mux = 32'h0;
            endcase
        end
    endfunction : rd_mux

    // ------------------------------------------------------------------------
    // Per-channel sources and pointer steppers
    // ------------------------------------------------------------------------
    dsc_src_sel #(
        .HAS_EXT (1'b0)
    ) u_src_a (
        .sel          (st.ch[0].ctrl[2:0]),
        .timer_cmp    (timer_cmp),
        .ser_tx_empty (ser_tx_empty),
        .ser_rx_full  (ser_rx_full),
        .ext_fall     (1'b0),
        .ext_low      (1'b0),
        .fire         (fire[0]),
        .rx_src       (rx_src[0]),
        .full_addr    (full[0])
    );

    dsc_src_sel #(
        .HAS_EXT (1'b1)
    ) u_src_b (
        .sel          (st.ch[1].ctrl[2:0]),
        .timer_cmp    (timer_cmp),
        .ser_tx_empty (ser_tx_empty),
        .ser_rx_full  (ser_rx_full),
        .ext_fall     (ext_fall),
        .ext_low      (!ext_xfer_request_n),
        .fire         (fire[1]),
        .rx_src       (rx_src[1]),
        .full_addr    (full[1])
    );

    for (genvar g = 0; g < 2; g++) begin : gen_step
        dsc_addr_step u_step (
            .ptr      (st.ch[g].mem_ptr),
            .word     (st.ch[g].ctrl[`DSC_BIT_SIZE]),
            .dir      (st.ch[g].ctrl[`DSC_BIT_DIR]),
            .hold     (mode_of(st.ch[g].ctrl) == DSC_MODE_IDLE),
            .next_ptr (step_ptr[g])
        );
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        logic       old_en;
        logic       hit;
        logic       g;
        logic [7:0] hi;
        logic [2:0] sel;
        old_en  = 1'b0;
        hit     = 1'b0;
        g       = 1'b0;
        hi      = 8'h00;
        sel     = 3'h0;
        next_st = st;

        for (int i = 0; i < 2; i++) begin
            old_en = st.ch[i].ctrl[`DSC_BIT_ENABLE];
            // Transfer completion updates pointer and count.
            if (st.arb == DSC_ARB_BUSY && st.gnt == 1'(i) && xfer_ack) begin
                next_st.ch[i].mem_ptr = step_ptr[i];
                if (mode_of(st.ch[i].ctrl) == DSC_MODE_REPEAT) begin
                    hi = st.ch[i].count[15:8] - 8'h01;
                    next_st.ch[i].count[15:8] = (hi == 8'h00) ? st.ch[i].count[7:0] : hi;
                end else begin
                    next_st.ch[i].count = st.ch[i].count - 16'h0001;
                    if (st.ch[i].count == 16'h0001) begin
                        next_st.ch[i].ctrl[`DSC_BIT_ENABLE] = 1'b0;
                    end
                end
            end
            // Register writes; software wins over the hardware update.
            hit = acc && addr_ok && (paddr[7:5] == 3'b000) && (paddr[4] == 1'(i));
            if (hit && pwrite) begin
                unique case (paddr[3:0])
                    `DSC_OFS_CTRL: begin
                        next_st.ch[i].ctrl[6:0] = pwdata[6:0];
                        next_st.ch[i].ctrl[`DSC_BIT_ENABLE] = pwdata[`DSC_BIT_ENABLE]
                            && (st.ch[i].set_ok || next_st.ch[i].ctrl[`DSC_BIT_ENABLE]);
                        next_st.ch[i].set_ok = 1'b0;
                    end
                    `DSC_OFS_MEM_PTR: next_st.ch[i].mem_ptr = pwdata[23:0];
                    `DSC_OFS_IO_PTR:  next_st.ch[i].io_ptr  = pwdata[7:0];
                    `DSC_OFS_COUNT:   next_st.ch[i].count   = pwdata[15:0];
                    default:          next_st.ch[i].count   = next_st.ch[i].count;
                endcase
            end
            if (hit && !pwrite && paddr[3:0] == `DSC_OFS_CTRL && !old_en) begin
                next_st.ch[i].set_ok = 1'b1;
            end
            if (standby) begin
                next_st.ch[i].ctrl   = `DSC_CTRL_RESET;
                next_st.ch[i].set_ok = 1'b0;
            end
            // A request is taken only while the channel stays enabled.
            if (fire[i] && old_en && !full[i]) begin
                next_st.ch[i].pend = 1'b1;
            end
            if (!next_st.ch[i].ctrl[`DSC_BIT_ENABLE]) begin
                next_st.ch[i].pend = 1'b0;
            end
            // End interrupt: clear first so that a new event wins.
            if ((acc && pwrite && paddr == `DSC_STAT_ADDR && pwdata[i])
                || !next_st.ch[i].ctrl[`DSC_BIT_IRQ_EN]) begin
                next_st.ch[i].end_irq = 1'b0;
            end
            if (old_en && !next_st.ch[i].ctrl[`DSC_BIT_ENABLE]
                && next_st.ch[i].ctrl[`DSC_BIT_IRQ_EN]) begin
                next_st.ch[i].end_irq = 1'b1;
            end
        end

        // Fixed priority: channel A before channel B on a shared source.
        unique case (st.arb)
            DSC_ARB_IDLE: begin
                if (next_st.ch[0].pend || next_st.ch[1].pend) begin
                    g = !next_st.ch[0].pend;
                    next_st.arb       = DSC_ARB_BUSY;
                    next_st.gnt       = g;
                    next_st.xfer_req  = 1'b1;
                    next_st.xfer_chan = g;
                    next_st.xfer_word = next_st.ch[g].ctrl[`DSC_BIT_SIZE];
                    next_st.ch[g].pend = 1'b0;
                    if (rx_src[g]) begin
                        next_st.xfer_src_addr = {`DSC_IO_HIGH, next_st.ch[g].io_ptr};
                        next_st.xfer_dst_addr = next_st.ch[g].mem_ptr;
                    end else begin
                        next_st.xfer_src_addr = next_st.ch[g].mem_ptr;
                        next_st.xfer_dst_addr = {`DSC_IO_HIGH, next_st.ch[g].io_ptr};
                    end
                end
            end
            DSC_ARB_BUSY: begin
                if (xfer_ack) begin
                    next_st.arb      = DSC_ARB_IDLE;
                    next_st.xfer_req = 1'b0;
                end
            end
        endcase

        next_st.src_irq_block = 6'h00;
        for (int i = 0; i < 2; i++) begin
            sel = next_st.ch[i].ctrl[2:0];
            if (next_st.ch[i].ctrl[`DSC_BIT_ENABLE] && sel <= `DSC_SRC_INT_LAST) begin
                next_st.src_irq_block[sel] = 1'b1;
            end
        end

        next_st.ext_prev = ext_xfer_request_n;
        next_st.pready   = setup;
        next_st.pslverr  = setup && !addr_ok;
        if (setup) begin
            next_st.prdata = rd_mux(st, paddr);
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata           = st.prdata;
    assign pready           = st.pready;
    assign pslverr          = st.pslverr;
    assign xfer_req         = st.xfer_req;
    assign xfer_chan        = st.xfer_chan;
    assign xfer_word        = st.xfer_word;
    assign xfer_src_addr    = st.xfer_src_addr;
    assign xfer_dst_addr    = st.xfer_dst_addr;
    assign transfer_end_irq = {st.ch[1].end_irq, st.ch[0].end_irq};
    assign src_irq_block    = st.src_irq_block;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_last_io_a;
        st.arb == DSC_ARB_BUSY && !st.gnt && xfer_ack
        && !st.ch[0].ctrl[`DSC_BIT_REPEAT] && st.ch[0].count == 16'h0001;
    endsequence

    sequence s_wrap_rep_b;
        st.arb == DSC_ARB_BUSY && st.gnt && xfer_ack
        && mode_of(st.ch[1].ctrl) == DSC_MODE_REPEAT && st.ch[1].count[15:8] == 8'h01
        && !(acc && pwrite);
    endsequence

    a_standby_clear: assert property (
        standby |=> st.ch[0].ctrl == 8'h00 && st.ch[1].ctrl == 8'h00)
        else $error("Control register not cleared by standby.");

    a_enable_after_read: assert property (
        $rose(st.ch[0].ctrl[`DSC_BIT_ENABLE]) |-> $past(st.ch[0].set_ok))
        else $error("Enable set without a prior read.");

    a_disabled_no_pend: assert property (
        !st.ch[1].ctrl[`DSC_BIT_ENABLE] |-> !st.ch[1].pend)
        else $error("Disabled channel holds a request.");

    a_last_io_ends: assert property (
        s_last_io_a |=> !st.ch[0].ctrl[`DSC_BIT_ENABLE] && st.arb == DSC_ARB_IDLE)
        else $error("Enable not cleared after last transfer.");

    a_end_irq_raise: assert property (
        $fell(st.ch[0].ctrl[`DSC_BIT_ENABLE]) && st.ch[0].ctrl[`DSC_BIT_IRQ_EN]
        |-> st.ch[0].end_irq)
        else $error("End interrupt missing on enable fall.");

    a_repeat_reload: assert property (
        s_wrap_rep_b |=> st.ch[1].count[15:8] == $past(st.ch[1].count[7:0], 1))
        else $error("Repeat count not reloaded.");

    a_idle_ptr_hold: assert property (
        st.arb == DSC_ARB_BUSY && !st.gnt && xfer_ack
        && mode_of(st.ch[0].ctrl) == DSC_MODE_IDLE && !(acc && pwrite)
        |=> $stable(st.ch[0].mem_ptr))
        else $error("Idle mode stepped the memory pointer.");

    a_prio_a_first: assert property (
        st.arb == DSC_ARB_IDLE && fire == 2'b11 && st.ch[0].ctrl[`DSC_BIT_ENABLE]
        && st.ch[1].ctrl[`DSC_BIT_ENABLE] && !standby && !(acc && pwrite)
        |=> xfer_req && !xfer_chan && st.ch[1].pend)
        else $error("Channel B served before channel A.");

    a_src_blocked: assert property (
        st.ch[1].ctrl[`DSC_BIT_ENABLE] && st.ch[1].ctrl[2:0] == 3'h4 |-> src_irq_block[4])
        else $error("Enabled source not blocked.");

    a_irq_pending: assert property (
        st.ch[0].end_irq && st.ch[0].ctrl[`DSC_BIT_IRQ_EN] && !(acc && pwrite) && !standby
        |=> st.ch[0].end_irq)
        else $error("End interrupt dropped without acknowledge.");

endmodule : dsc_chan_ctrl

// *** hdl/dsc_regs.svh ***
// Register offsets, field positions and reset values of the short address channel pair.
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define DSC_CH_A_BASE    8'h00
`define DSC_CH_B_BASE    8'h10
`define DSC_OFS_CTRL     4'h0
`define DSC_OFS_MEM_PTR  4'h4
`define DSC_OFS_IO_PTR   4'h8
`define DSC_OFS_COUNT    4'hc
`define DSC_STAT_ADDR    8'h20

// ----------------------------------------------------------------------------
// Control register fields and constants
// ----------------------------------------------------------------------------
`define DSC_BIT_ENABLE   7
`define DSC_BIT_SIZE     6
`define DSC_BIT_DIR      5
`define DSC_BIT_REPEAT   4
`define DSC_BIT_IRQ_EN   3
`define DSC_CTRL_RESET   8'h00
`define DSC_SRC_FULL     2'b11
`define DSC_SRC_INT_LAST 3'h5
`define DSC_IO_HIGH      16'hffff
`define DSC_MEM_RSVD     8'hff

`endif

// *** hdl/dsc_pkg.sv ***
// Types shared by the short address channel pair.
package dsc_pkg;

    typedef enum logic [1:0] {
        DSC_MODE_IO     = 2'b00,
        DSC_MODE_REPEAT = 2'b01,
        DSC_MODE_IDLE   = 2'b10
    } dsc_mode_type;

    typedef enum logic {
        DSC_ARB_IDLE = 1'b0,
        DSC_ARB_BUSY = 1'b1
    } dsc_arb_type;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [23:0] mem_ptr;
        logic [7:0]  io_ptr;
        logic [15:0] count;
        logic        set_ok;
        logic        pend;
        logic        end_irq;
    } dsc_chan_type;

    typedef struct packed {
        dsc_chan_type [1:0] ch;
        dsc_arb_type        arb;
        logic               gnt;
        logic               ext_prev;
        logic               xfer_req;
        logic               xfer_word;
        logic               xfer_chan;
        logic [23:0]        xfer_src_addr;
        logic [23:0]        xfer_dst_addr;
        logic [31:0]        prdata;
        logic               pready;
        logic               pslverr;
        logic [5:0]         src_irq_block;
    } dsc_state_type;

endpackage : dsc_pkg

// *** hdl/dsc_src_sel.sv ***
// Activation source decoder for one channel.
module dsc_src_sel
    import dsc_pkg::*;
#(
    parameter bit HAS_EXT = 1'b0
) (
    input  wire logic [2:0] sel,
    input  wire logic [3:0] timer_cmp,
    input  wire logic       ser_tx_empty,
    input  wire logic       ser_rx_full,
    input  wire logic       ext_fall,
    input  wire logic       ext_low,
    output logic            fire,
    output logic            rx_src,
    output logic            full_addr
);

    // ------------------------------------------------------------------------
    // Source mux
    // ------------------------------------------------------------------------
    always_comb begin
        unique case (sel)
            3'h0, 3'h1, 3'h2, 3'h3: fire = timer_cmp[sel[1:0]];
            3'h4:                   fire = ser_tx_empty;
            3'h5:                   fire = ser_rx_full;
            3'h6:                   fire = HAS_EXT && ext_fall;
            3'h7:                   fire = HAS_EXT && ext_low;
        endcase
    end

    assign rx_src    = (sel == 3'h5);
    // Codes 6 and 7 hand channel A over to the full address engine.
    assign full_addr = !HAS_EXT && (sel[2:1] == 2'b11);

endmodule : dsc_src_sel

// *** hdl/dsc_addr_step.sv ***
// Memory pointer stepper for one channel.
module dsc_addr_step (
    input  wire logic [23:0] ptr,
    input  wire logic        word,
    input  wire logic        dir,
    input  wire logic        hold,
    output logic [23:0]      next_ptr
);

    logic [23:0] step;

    assign step = word ? 24'h000002 : 24'h000001;

    // ------------------------------------------------------------------------
    // Step
    // ------------------------------------------------------------------------
    always_comb begin
        if (hold) begin
            next_ptr = ptr;
        end else if (dir) begin
            next_ptr = ptr - step;
        end else begin
            next_ptr = ptr + step;
        end
    end

endmodule : dsc_addr_step

// *** tb/dsc_far_end.sv ***
// Far-side model: bus engine that acknowledges transfers, and the external requester pin.
module dsc_far_end (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic xfer_req,
    input  wire logic ack_slow,
    input  wire logic ext_fall_go,
    output logic      xfer_ack,
    output logic      ext_xfer_request_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_cnt;
    // A slow engine keeps the request waiting, so held outputs are exercised.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !xfer_req || xfer_ack) begin
            wait_cnt <= 3'h0;
            xfer_ack <= 1'b0;
        end else if (wait_cnt >= (ack_slow ? 3'h3 : 3'h0)) begin
            xfer_ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 3'h1;
        end
    end
    // The pin idles high; a request is one low cycle, which gives a falling edge.
    always_ff @(posedge sys_clk) begin
        ext_xfer_request_n <= sys_rst | ~ext_fall_go;
    end
endmodule : dsc_far_end

// *** tb/tb_dsc_chan_ctrl.sv ***
// Self-checking bench of the short address channel pair.
`include "dsc_regs.svh"
module tb_dsc_chan_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, sys_rst, standby, psel, penable, pwrite, pready, pslverr, rd_err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic [3:0]  timer_cmp;
    logic        ser_tx_empty, ser_rx_full, ext_xfer_request_n, ext_fall_go, ack_slow;
    logic        xfer_req, xfer_chan, xfer_word, xfer_ack;
    logic [23:0] xfer_src_addr, xfer_dst_addr;
    logic [1:0]  transfer_end_irq;
    logic [5:0]  src_irq_block;
    int          failures, n_compared;
    dsc_chan_ctrl dsc_chan_ctrl_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .standby(standby),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_cmp(timer_cmp),
        .ser_tx_empty(ser_tx_empty), .ser_rx_full(ser_rx_full),
        .ext_xfer_request_n(ext_xfer_request_n), .xfer_req(xfer_req), .xfer_chan(xfer_chan),
        .xfer_word(xfer_word), .xfer_src_addr(xfer_src_addr), .xfer_dst_addr(xfer_dst_addr),
        .xfer_ack(xfer_ack), .transfer_end_irq(transfer_end_irq),
        .src_irq_block(src_irq_block));
    dsc_far_end dsc_far_end_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .xfer_req(xfer_req),
        .ack_slow(ack_slow), .ext_fall_go(ext_fall_go), .xfer_ack(xfer_ack),
        .ext_xfer_request_n(ext_xfer_request_n));
    always #5 sys_clk = ~sys_clk;
    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    function automatic logic [7:0] ra(input logic ch, input logic [3:0] ofs);
        return (ch ? `DSC_CH_B_BASE : `DSC_CH_A_BASE) + {4'h0, ofs};
    endfunction : ra
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    task automatic hang;
        failures++;
        $display("MISMATCH wait_bound expected done seen timeout");
        give_verdict();
    endtask : hang
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // The request is held until pready is sampled high; no latency is assumed.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (n > 20) hang();
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd_data);
    endtask : rd_chk
    task automatic wait_req(input logic v);
        int n;
        n = 0;
        while (xfer_req !== v) begin
            @(posedge sys_clk);
            n++;
            if (n > 50) hang();
        end
    endtask : wait_req
    task automatic pulse(input logic [6:0] ev);
        @(posedge sys_clk);
        {ext_fall_go, ser_rx_full, ser_tx_empty, timer_cmp} <= ev;
        @(posedge sys_clk);
        {ext_fall_go, ser_rx_full, ser_tx_empty, timer_cmp} <= 7'h00;
    endtask : pulse
    task automatic fire(input logic [6:0] ev, input logic ch, input logic w,
                        input logic [23:0] s, input logic [23:0] d);
        pulse(ev);
        wait_req(1'b1);
        chk("xfer_chan", 32'(ch), 32'(xfer_chan));
        chk("xfer_word", 32'(w), 32'(xfer_word));
        chk("xfer_src_addr", 32'(s), 32'(xfer_src_addr));
        chk("xfer_dst_addr", 32'(d), 32'(xfer_dst_addr));
        wait_req(1'b0);
    endtask : fire
    task automatic setup(input logic ch, input logic [23:0] mem, input logic [7:0] io,
                         input logic [15:0] cnt, input logic [7:0] ctrl);
        apb(1'b1, ra(ch, `DSC_OFS_MEM_PTR), {8'h00, mem});
        apb(1'b1, ra(ch, `DSC_OFS_IO_PTR), {24'h0, io});
        apb(1'b1, ra(ch, `DSC_OFS_COUNT), {16'h0, cnt});
        apb(1'b0, ra(ch, `DSC_OFS_CTRL), 32'h0);
        apb(1'b1, ra(ch, `DSC_OFS_CTRL), {24'h0, ctrl});
    endtask : setup
    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset_permit;
        rd_chk("ctrl_b", ra(1'b1, `DSC_OFS_CTRL), 32'h0);
        apb(1'b1, ra(1'b0, `DSC_OFS_CTRL), 32'h80);
        rd_chk("ctrl_a", ra(1'b0, `DSC_OFS_CTRL), 32'h0);
        apb(1'b0, 8'h24, 32'h0);
        chk("pslverr", 32'h1, 32'(rd_err));
        $display("test reset_permit done");
    endtask : t_reset_permit
    task automatic t_io_mode;
        setup(1'b0, 24'h000100, 8'h40, 16'h0002, 8'h88);
        fire(7'h01, 1'b0, 1'b0, 24'h000100, 24'hffff40);
        fire(7'h01, 1'b0, 1'b0, 24'h000101, 24'hffff40);
        rd_chk("mem_a", ra(1'b0, `DSC_OFS_MEM_PTR), 32'hff000102);
        rd_chk("count_a", ra(1'b0, `DSC_OFS_COUNT), 32'h0);
        rd_chk("ctrl_a", ra(1'b0, `DSC_OFS_CTRL), 32'h08);
        chk("end_irq", 32'h1, 32'(transfer_end_irq));
        apb(1'b1, `DSC_STAT_ADDR, 32'h1);
        @(posedge sys_clk);
        chk("end_irq", 32'h0, 32'(transfer_end_irq));
        pulse(7'h01);
        repeat (5) @(posedge sys_clk);
        chk("xfer_req", 32'h0, 32'(xfer_req));
        $display("test io_mode done");
    endtask : t_io_mode
    task automatic t_repeat;
        ack_slow <= 1'b1;
        setup(1'b1, 24'h000200, 8'h50, 16'h0102, 8'hf4);
        fire(7'h10, 1'b1, 1'b1, 24'h000200, 24'hffff50);
        chk("src_irq_block", 32'h10, 32'(src_irq_block));
        rd_chk("mem_b", ra(1'b1, `DSC_OFS_MEM_PTR), 32'hff0001fe);
        rd_chk("count_b", ra(1'b1, `DSC_OFS_COUNT), 32'h0202);
        rd_chk("ctrl_b", ra(1'b1, `DSC_OFS_CTRL), 32'hf4);
        apb(1'b1, ra(1'b1, `DSC_OFS_CTRL), 32'h74);
        rd_chk("ctrl_b", ra(1'b1, `DSC_OFS_CTRL), 32'h74);
        chk("src_irq_block", 32'h0, 32'(src_irq_block));
        chk("end_irq", 32'h0, 32'(transfer_end_irq));
        ack_slow <= 1'b0;
        $display("test repeat done");
    endtask : t_repeat
    task automatic t_idle_ext;
        setup(1'b0, 24'h000300, 8'h60, 16'h0001, 8'h9d);
        fire(7'h20, 1'b0, 1'b0, 24'hffff60, 24'h000300);
        rd_chk("mem_a", ra(1'b0, `DSC_OFS_MEM_PTR), 32'hff000300);
        rd_chk("ctrl_a", ra(1'b0, `DSC_OFS_CTRL), 32'h1d);
        chk("end_irq", 32'h1, 32'(transfer_end_irq));
        apb(1'b1, `DSC_STAT_ADDR, 32'h1);
        setup(1'b1, 24'h000400, 8'h70, 16'h0001, 8'h86);
        fire(7'h40, 1'b1, 1'b0, 24'h000400, 24'hffff70);
        rd_chk("ctrl_b", ra(1'b1, `DSC_OFS_CTRL), 32'h06);
        setup(1'b1, 24'h000410, 8'h71, 16'h0001, 8'h87);
        fire(7'h40, 1'b1, 1'b0, 24'h000410, 24'hffff71);
        chk("end_irq", 32'h0, 32'(transfer_end_irq));
        $display("test idle_ext done");
    endtask : t_idle_ext
    task automatic t_priority;
        setup(1'b0, 24'h000500, 8'h80, 16'h0001, 8'h81);
        setup(1'b1, 24'h000600, 8'h90, 16'h0001, 8'h81);
        fire(7'h02, 1'b0, 1'b0, 24'h000500, 24'hffff80);
        fire(7'h00, 1'b1, 1'b0, 24'h000600, 24'hffff90);
        $display("test priority done");
    endtask : t_priority
    task automatic t_standby;
        setup(1'b0, 24'h000000, 8'h00, 16'h0005, 8'h80);
        rd_chk("ctrl_a", ra(1'b0, `DSC_OFS_CTRL), 32'h80);
        @(posedge sys_clk);
        standby <= 1'b1;
        @(posedge sys_clk);
        standby <= 1'b0;
        rd_chk("ctrl_a", ra(1'b0, `DSC_OFS_CTRL), 32'h0);
        $display("test standby done");
    endtask : t_standby
    initial begin
        sys_clk = 1'b0;
        {sys_rst, standby, psel, penable, pwrite, ack_slow, ext_fall_go} = 7'h40;
        {ser_tx_empty, ser_rx_full, timer_cmp, paddr, pwdata} = '0;
        failures = 0;
        n_compared = 0;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset_permit();
        t_io_mode();
        t_repeat();
        t_idle_ext();
        t_priority();
        t_standby();
        give_verdict();
    end
endmodule : tb_dsc_chan_ctrl
